// [strap_sample_status_pins.sv]
// strap sampling at reset release and status indication on shared pins
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "strap_params.svh"
module strap_sample_status_pins (
  input  wire logic                     sys_clk_i,
  input  wire logic                     resetn_i,
  // apb slave
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [`APB_ADDR_W-1:0]   paddr_i,
  input  wire logic [31:0]              pwdata_i,
  output logic [31:0]                   prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o,
  // shared pin: gang select / hs connected
  input  wire logic                     gang_pin_i,
  output logic                          gang_pin_o,
  output logic                          gang_pin_oe_n_o,
  // shared pin: auto charge disable / hs suspended
  input  wire logic                     auto_pin_i,
  output logic                          auto_pin_o,
  output logic                          auto_pin_oe_n_o,
  // plain strap inputs and reserved test input
  input  wire logic                     bus_mode_strap_i,
  input  wire logic                     power_switch_disable_strap_i,
  input  wire logic                     test_i,
  // live upstream state from the hub core
  input  wire logic                     hs_connected_i,
  input  wire logic                     hs_suspended_i,
  // decoded configuration toward the hub core
  output logic                          ganged_power_o,
  output logic                          individual_power_o,
  output logic                          smbus_mode_o,
  output logic                          smbus_addr_bit2_strap_o,
  output logic                          power_switch_en_o,
  output logic                          auto_charge_disable_bit_o,
  output logic                          auto_charge_mode_o,
  output logic                          cdp_port1_allow_o
);
  // ------------------------------------------------------------
  // reset phase sequencing
  // ------------------------------------------------------------
  strap_pkg::phase_e phase_reg;
  strap_pkg::phase_e phase_next;
  strap_pkg::strap_s pins;
  strap_pkg::strap_s straps;
  logic              load;
  logic              done;

  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      strap_pkg::ST_RESET:   phase_next = strap_pkg::ST_CAPTURE;
      strap_pkg::ST_CAPTURE: phase_next = strap_pkg::ST_RUN;
      strap_pkg::ST_RUN:     phase_next = strap_pkg::ST_RUN;
      default:               phase_next = strap_pkg::ST_RESET;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_reg <= strap_pkg::ST_RESET;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ------------------------------------------------------------
  // capture strobe
  // ------------------------------------------------------------
  // first edge after release samples the pins while still undriven
  assign load = (phase_reg == strap_pkg::ST_RESET);
  assign done = (phase_reg == strap_pkg::ST_RUN);

  // ------------------------------------------------------------
  // strap pin capture
  // ------------------------------------------------------------
  assign pins.gang_sel   = gang_pin_i;
  assign pins.auto_dis_n = auto_pin_i;
  assign pins.bus_mode   = bus_mode_strap_i;
  assign pins.pwr_sw_dis = power_switch_disable_strap_i;

  // ------------------------------------------------------------
  // strap holding register
  // ------------------------------------------------------------
  strap_latch u_latch (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .load_i    (load),
    .pins_i    (pins),
    .value_o   (straps)
  );

  // ------------------------------------------------------------
  // decoded configuration
  // ------------------------------------------------------------
  function automatic logic [`CFG_W-1:0] decode_cfg(input strap_pkg::strap_s s,
                                                   input logic              run);
    logic [`CFG_W-1:0] c;
    logic              sw_en;
    logic              smb;
    logic              auto_on;
    sw_en                = ~s.pwr_sw_dis & run;
    smb                  = ~s.bus_mode & run;
    auto_on              = ~s.auto_dis_n & run;
    c                    = '0;
    c[`CFG_PWRSW_BIT]    = sw_en;
    c[`CFG_GANGED_BIT]   = sw_en & s.gang_sel;
    c[`CFG_INDIV_BIT]    = sw_en & ~s.gang_sel;
    c[`CFG_SMBUS_BIT]    = smb;
    c[`CFG_SMBUS_ADDR_BIT2_STRAP_BIT]    = smb & s.gang_sel;
    c[`CFG_AUTO_BIT]     = auto_on;
    c[`CFG_CDP1_BIT]     = ~auto_on;
    c[`CFG_AUTODIS_BIT]  = s.auto_dis_n;
    return c;
  endfunction

  strap_pkg::strap_s  straps_next;
  logic [`CFG_W-1:0]  cfg_now;
  logic [`CFG_W-1:0]  cfg_next;
  logic [`CFG_W-1:0]  cfg_reg;
  wire logic          done_next = (phase_next == strap_pkg::ST_RUN);

  assign straps_next = load ? pins : straps;
  assign cfg_now     = decode_cfg(straps, done);
  assign cfg_next    = decode_cfg(straps_next, done_next);

  wire logic pwr_sw_en    = cfg_now[`CFG_PWRSW_BIT];
  wire logic ganged       = cfg_now[`CFG_GANGED_BIT];
  wire logic individual   = cfg_now[`CFG_INDIV_BIT];
  wire logic smbus_mode   = cfg_now[`CFG_SMBUS_BIT];
  wire logic smbus_addr_bit2_strap        = cfg_now[`CFG_SMBUS_ADDR_BIT2_STRAP_BIT];
  wire logic auto_mode    = cfg_now[`CFG_AUTO_BIT];
  wire logic cdp1_allow   = cfg_now[`CFG_CDP1_BIT];
  wire logic auto_dis_bit = cfg_now[`CFG_AUTODIS_BIT];

  // ------------------------------------------------------------
  // registered configuration outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_reg <= `CFG_RESET_VAL;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign power_switch_en_o         = cfg_reg[`CFG_PWRSW_BIT];
  assign ganged_power_o            = cfg_reg[`CFG_GANGED_BIT];
  assign individual_power_o        = cfg_reg[`CFG_INDIV_BIT];
  assign smbus_mode_o              = cfg_reg[`CFG_SMBUS_BIT];
  assign smbus_addr_bit2_strap_o   = cfg_reg[`CFG_SMBUS_ADDR_BIT2_STRAP_BIT];
  assign auto_charge_mode_o        = cfg_reg[`CFG_AUTO_BIT];
  assign cdp_port1_allow_o         = cfg_reg[`CFG_CDP1_BIT];
  assign auto_charge_disable_bit_o = cfg_reg[`CFG_AUTODIS_BIT];

  // ------------------------------------------------------------
  // status pin drive
  // ------------------------------------------------------------
  logic [1:0] feature_reg;
  logic [1:0] feature_next;
  logic       hs_upstream_connected_reg;
  logic       hs_sus_reg;
  logic       gang_oe_n_reg;
  logic       auto_oe_n_reg;

  // enables from flops, computed from next-edge values: no decode glitch on the pins
  wire logic hsup_en  = feature_next[`FT_HSUP_EN_BIT] & done_next;
  wire logic hssus_en = feature_next[`FT_HSSUS_EN_BIT] & done_next;

  // ------------------------------------------------------------
  // live upstream state
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hs_upstream_connected_reg  <= 1'b0;
      hs_sus_reg <= 1'b0;
    end else begin
      hs_upstream_connected_reg  <= hs_connected_i;
      hs_sus_reg <= hs_suspended_i;
    end
  end

  // ------------------------------------------------------------
  // pin enables
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gang_oe_n_reg <= `PIN_RELEASE_VAL;
      auto_oe_n_reg <= `PIN_RELEASE_VAL;
    end else begin
      gang_oe_n_reg <= ~hsup_en;
      auto_oe_n_reg <= ~hssus_en;
    end
  end

  assign gang_pin_o      = hs_upstream_connected_reg;
  assign gang_pin_oe_n_o = gang_oe_n_reg;
  assign auto_pin_o      = hs_sus_reg;
  assign auto_pin_oe_n_o = auto_oe_n_reg;

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  function automatic logic reg_hit(input logic [`APB_ADDR_W-1:0] addr,
                                   input logic [`APB_ADDR_W-1:0] offs);
    return (addr == offs);
  endfunction

  wire logic acc      = psel_i & penable_i;
  wire logic hit_stat = reg_hit(paddr_i, `STRAP_REG_STATUS);
  wire logic hit_feat = reg_hit(paddr_i, `STRAP_REG_FEATURE);
  wire logic hit_st   = reg_hit(paddr_i, `STRAP_REG_STATE);
  wire logic hit_any  = hit_stat | hit_feat | hit_st;
  wire logic wr_feat  = acc & pwrite_i & hit_feat;

  // ------------------------------------------------------------
  // read word packing
  // ------------------------------------------------------------
  logic [31:0] stat_word;
  logic [31:0] state_word;
  logic [31:0] rd_mux;
  logic [31:0] prdata_reg;

  always_comb begin
    stat_word = 32'h0;
    stat_word[`ST_GANG_BIT]    = straps.gang_sel;
    stat_word[`ST_SMBUS_ADDR_BIT2_STRAP_BIT]   = smbus_addr_bit2_strap;
    stat_word[`ST_AUTODIS_BIT] = auto_dis_bit;
    stat_word[`ST_BUSMODE_BIT] = straps.bus_mode;
    stat_word[`ST_PWRDIS_BIT]  = straps.pwr_sw_dis;
    stat_word[`ST_DONE_BIT]    = done;
    state_word = 32'h0;
    state_word[`SS_INDIV_BIT]   = individual;
    state_word[`SS_GANGED_BIT]  = ganged;
    state_word[`SS_SMBADDR_BIT] = smbus_mode;
    state_word[`SS_AUTO_BIT]    = auto_mode;
    state_word[`SS_CDP1_BIT]    = cdp1_allow;
    state_word[`SS_PWRSW_BIT]   = pwr_sw_en;
  end

  // ------------------------------------------------------------
  // read selection
  // ------------------------------------------------------------
  always_comb begin
    if (hit_stat) begin
      rd_mux = stat_word;
    end else if (hit_feat) begin
      rd_mux = {30'h0, feature_reg};
    end else if (hit_st) begin
      rd_mux = state_word;
    end else begin
      rd_mux = 32'h0;
    end
  end

  // ------------------------------------------------------------
  // feature register
  // ------------------------------------------------------------
  assign feature_next = wr_feat ? pwdata_i[1:0] : feature_reg;

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      feature_reg <= `FT_RESET_VAL;
    end else begin
      feature_reg <= feature_next;
    end
  end

  // ------------------------------------------------------------
  // read data register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_reg <= 32'h0;
    end else if (psel_i & ~penable_i & ~pwrite_i) begin
      prdata_reg <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // reserved input and bus response
  // ------------------------------------------------------------
  // test_i is reserved and deliberately ignored
  wire logic unused_test = test_i;

  assign prdata_o  = prdata_reg;
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~hit_any;
endmodule

// [strap_params.svh]
// constants for the strap capture and status pin block
`ifndef STRAP_PARAMS_SVH
`define STRAP_PARAMS_SVH

// apb register byte offsets
`define STRAP_REG_STATUS  12'h000
`define STRAP_REG_FEATURE 12'h004
`define STRAP_REG_STATE   12'h008

// status register fields (captured straps, decoded smbus address bit and done flag, read only)
`define ST_GANG_BIT      0
`define ST_SMBUS_ADDR_BIT2_STRAP_BIT     1
`define ST_AUTODIS_BIT   2
`define ST_BUSMODE_BIT   3
`define ST_PWRDIS_BIT    4
`define ST_DONE_BIT      5

// feature register fields
`define FT_HSUP_EN_BIT   0
`define FT_HSSUS_EN_BIT  1
`define FT_RESET_VAL     2'h0

// state register fields (live derived state, read only)
`define SS_INDIV_BIT     0
`define SS_GANGED_BIT    1
`define SS_SMBADDR_BIT   2
`define SS_AUTO_BIT      3
`define SS_CDP1_BIT      4
`define SS_PWRSW_BIT     5

// decoded configuration vector fields
`define CFG_W            8
`define CFG_INDIV_BIT    0
`define CFG_GANGED_BIT   1
`define CFG_SMBUS_BIT    2
`define CFG_SMBUS_ADDR_BIT2_STRAP_BIT    3
`define CFG_PWRSW_BIT    4
`define CFG_AUTODIS_BIT  5
`define CFG_AUTO_BIT     6
`define CFG_CDP1_BIT     7
`define CFG_RESET_VAL    8'h80

// output enable level that leaves a shared pin undriven
`define PIN_RELEASE_VAL  1'b1

`define APB_ADDR_W       12
`endif

// [strap_pkg.sv]
// types for the strap capture and status pin block
package strap_pkg;
  typedef struct packed {
    logic gang_sel;
    logic auto_dis_n;
    logic bus_mode;
    logic pwr_sw_dis;
  } strap_s;

  typedef enum logic [1:0] {
    ST_RESET   = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_RUN     = 2'b10
  } phase_e;
endpackage

// [strap_latch.sv]
// holding register for the captured strap levels
`timescale 1ns/1ns
module strap_latch (
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             load_i,
  input  wire strap_pkg::strap_s pins_i,
  output strap_pkg::strap_s     value_o
);
  strap_pkg::strap_s value_reg;
  // ------------------------------------------------------------
  // capture once, then hold until next reset
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      value_reg <= '0;
    end else if (load_i) begin
      value_reg <= pins_i;
    end
  end
  assign value_o = value_reg;
endmodule

// [strap_chk.sv]
// assertions on the strap capture and status pin ports
`timescale 1ns/1ns
module strap_chk (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic gang_pin_o,
  input wire logic gang_pin_oe_n_o,
  input wire logic auto_pin_o,
  input wire logic auto_pin_oe_n_o,
  input wire logic hs_connected_i,
  input wire logic hs_suspended_i,
  input wire logic ganged_power_o,
  input wire logic individual_power_o,
  input wire logic smbus_mode_o,
  input wire logic smbus_addr_bit2_strap_o,
  input wire logic power_switch_en_o,
  input wire logic auto_charge_disable_bit_o,
  input wire logic auto_charge_mode_o,
  input wire logic cdp_port1_allow_o
);
  // ----
  // edges since reset release, saturating
  // ----
  logic [1:0] cnt_reg;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) cnt_reg <= 2'h0;
    else if (cnt_reg != 2'h3) cnt_reg <= cnt_reg + 2'h1;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  a_power_mode: assert property (cnt_reg == 2'h3 |-> !(ganged_power_o && individual_power_o)
    && ((ganged_power_o || individual_power_o) == power_switch_en_o)) else $error("power mode");
  a_smb_addr: assert property (smbus_addr_bit2_strap_o |-> smbus_mode_o) else $error("addr bit");
  a_cdp_block: assert property (auto_charge_mode_o |-> !cdp_port1_allow_o) else $error("cdp");
  a_auto_bit: assert property (cnt_reg == 2'h3 |-> auto_charge_mode_o != auto_charge_disable_bit_o)
    else $error("auto bit");
  a_straps_hold: assert property (cnt_reg == 2'h3 |-> $stable({ganged_power_o, smbus_mode_o,
    auto_charge_disable_bit_o, power_switch_en_o})) else $error("strap changed");
  a_no_early: assert property (!cnt_reg[1] |-> gang_pin_oe_n_o && auto_pin_oe_n_o)
    else $error("early drive");
  a_conn_follow: assert property (!gang_pin_oe_n_o |-> gang_pin_o == $past(hs_connected_i))
    else $error("conn status");
  a_susp_follow: assert property (!auto_pin_oe_n_o |-> auto_pin_o == $past(hs_suspended_i))
    else $error("susp status");
endmodule
bind strap_sample_status_pins strap_chk strap_chk_i (.*);

// [strap_board.sv]
// board strap resistors and test input tie-off resolving the shared pins
`timescale 1ns/1ns
module strap_board (
  input  wire logic gang_lvl_i,
  input  wire logic auto_lvl_i,
  input  wire logic gang_o_i,
  input  wire logic gang_oe_n_i,
  input  wire logic auto_o_i,
  input  wire logic auto_oe_n_i,
  output logic      gang_pin_o,
  output logic      auto_pin_o,
  output logic      test_o
);
  // ----
  // strap level unless the device drives
  // ----
  assign gang_pin_o = gang_oe_n_i ? gang_lvl_i : gang_o_i;
  assign auto_pin_o = auto_oe_n_i ? auto_lvl_i : auto_o_i;
  assign test_o     = 1'b0;
endmodule

// [tb_top.sv]
// testbench for strap capture and status pins
`timescale 1ns/1ns
module tb_top;
  logic        sys_clk_i = 1'b0, resetn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        g_lvl = 1'b0, a_lvl = 1'b1, bus_s = 1'b1, pwr_s = 1'b0, hs_c = 1'b0, hs_s = 1'b0;
  logic        pready, pslverr, err, g_pin, g_o, g_oen, a_pin, a_o, a_oen, tst;
  logic [7:0]  dec;
  int          err_count = 0, samples_checked = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  strap_sample_status_pins strap_sample_status_pins_i (.sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .gang_pin_i(g_pin), .gang_pin_o(g_o), .gang_pin_oe_n_o(g_oen),
    .auto_pin_i(a_pin), .auto_pin_o(a_o), .auto_pin_oe_n_o(a_oen), .bus_mode_strap_i(bus_s),
    .power_switch_disable_strap_i(pwr_s), .test_i(tst), .hs_connected_i(hs_c),
    .hs_suspended_i(hs_s), .ganged_power_o(dec[7]), .individual_power_o(dec[6]),
    .smbus_mode_o(dec[5]), .smbus_addr_bit2_strap_o(dec[4]), .power_switch_en_o(dec[3]),
    .auto_charge_disable_bit_o(dec[2]), .auto_charge_mode_o(dec[1]), .cdp_port1_allow_o(dec[0]));
  strap_board strap_board_i (.gang_lvl_i(g_lvl), .auto_lvl_i(a_lvl), .gang_o_i(g_o),
    .gang_oe_n_i(g_oen), .auto_o_i(a_o), .auto_oe_n_i(a_oen), .gang_pin_o(g_pin),
    .auto_pin_o(a_pin), .test_o(tst));
  // ----
  // helpers
  // ----
  function automatic logic [7:0] exp_dec(input logic [3:0] s);
    return {~s[0] & s[3], ~s[0] & ~s[3], ~s[1], s[3] & ~s[1], ~s[0], s[2], ~s[2], s[2]};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic do_reset(input logic [3:0] s);
    {g_lvl, a_lvl, bus_s, pwr_s} <= s;
    resetn_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    for (int i = 0; i < 16; i++) begin
      do_reset(i[3:0]);
      chk("decoded", dec, exp_dec(i[3:0]));
      apb(1'b0, 12'h000, 32'h0);
      chk("status", rd, {26'h0, 1'b1, i[0], i[1], i[2], i[3] & ~i[1], i[3]});
      apb(1'b0, 12'h008, 32'h0);
      chk("state", rd, {26'h0, ~i[0], i[2], ~i[2], ~i[1], ~i[0] & i[3], ~i[0] & ~i[3]});
      {g_lvl, a_lvl, bus_s, pwr_s} <= ~i[3:0];
      repeat (2) @(posedge sys_clk_i);
      chk("held", dec, exp_dec(i[3:0]));
    end
    $display("strap capture test done");
    do_reset(4'h8);
    chk("undriven", {g_oen, a_oen, g_pin, a_pin}, 4'b1110);
    apb(1'b1, 12'h004, 32'hffffffff);
    apb(1'b1, 12'h000, 32'hffffffff);
    apb(1'b0, 12'h004, 32'h0);
    chk("feature", rd, 32'h3);
    apb(1'b0, 12'h000, 32'h0);
    chk("status ro", rd, 32'h23);
    for (int k = 0; k < 4; k++) begin
      {hs_c, hs_s} <= k[1:0];
      repeat (2) @(negedge sys_clk_i);
      chk("drive", {g_oen, a_oen, g_pin, a_pin}, {2'b00, k[1:0]});
      @(posedge sys_clk_i);
    end
    chk("kept", dec, exp_dec(4'h8));
    apb(1'b1, 12'h004, 32'h0);
    @(negedge sys_clk_i);
    chk("released", {g_oen, a_oen, g_pin, a_pin}, 4'b1110);
    @(posedge sys_clk_i);
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    $display("status pin test done");
    close_out();
  end
  initial begin
    #50000;
    err_count++;
    close_out();
  end
endmodule
